// ===== rtl/mcu8_exec_pkg.sv
package mcu8_exec_pkg;

  // ==========================================================
  // Operation codes presented by the sequencer
  // ==========================================================
  typedef enum logic [5:0] {
    OP_MOV_A_M, OP_MOV_M_A, OP_MOVB0_A_M, OP_MOVB0_M_A,
    OP_MOV_A_I, OP_MOVB0_M_I, OP_XCH, OP_XCHB0, OP_ROMRD,
    OP_ADC_A, OP_ADC_M, OP_ADD_A, OP_ADD_M, OP_ADDB0_M, OP_ADD_I,
    OP_SBC_A, OP_SBC_M, OP_SUB_A, OP_SUB_M, OP_SUB_I,
    OP_AND_A, OP_AND_M, OP_AND_I, OP_OR_A, OP_OR_M, OP_OR_I,
    OP_XOR_A, OP_XOR_M, OP_XOR_I,
    OP_SWAP_A, OP_SWAP_M, OP_RRC_A, OP_RRC_M, OP_RLC_A, OP_RLC_M,
    OP_CLR, OP_BIT_CLEAR, OP_BIT_SET
  } op_t;

  // ==========================================================
  // Address map and reset values
  // ==========================================================
  localparam logic [7:0] SYSREG_IMM_LO = 8'h80;
  localparam logic [7:0] SYSREG_IMM_HI = 8'h87;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] R_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] ROM_ADDR_RST = 16'h0000;
  localparam logic FLAG_RST = 1'b0;

  // ==========================================================
  // Cycle counts, held as extra cycles beyond the first
  // ==========================================================
  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_RAM = 2'h1;
  localparam logic [1:0] EXTRA_ROM = 2'h1;
  localparam logic [1:0] COUNT_LAST = 2'h1;

  // Operand below the system register space is data RAM
  function automatic logic is_ram(input logic [7:0] addr);
    is_ram = ~addr[7];
  endfunction : is_ram

  function automatic logic is_bank0(input op_t op);
    is_bank0 = (op == OP_MOVB0_A_M) || (op == OP_MOVB0_M_A) ||
               (op == OP_MOVB0_M_I) || (op == OP_XCHB0) ||
               (op == OP_ADDB0_M);
  endfunction : is_bank0

  function automatic logic [1:0] extra_cycles(input op_t op,
                                              input logic [7:0] addr);
    unique case (op)
      OP_ROMRD: extra_cycles = EXTRA_ROM;
      OP_XCH, OP_XCHB0, OP_ADC_M, OP_ADD_M, OP_ADDB0_M, OP_SBC_M,
      OP_SUB_M, OP_AND_M, OP_OR_M, OP_XOR_M, OP_SWAP_M, OP_RRC_M,
      OP_RLC_M, OP_BIT_CLEAR, OP_BIT_SET:
        extra_cycles = is_ram(addr) ? EXTRA_RAM : EXTRA_NONE;
      default: extra_cycles = EXTRA_NONE;
    endcase
  endfunction : extra_cycles

endpackage : mcu8_exec_pkg

// ===== rtl/mcu8_cycle_timer.sv
`timescale 1ns/1ps
module mcu8_cycle_timer
  import mcu8_exec_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic [1:0] i_extra,
  output logic o_fire
);

  logic [1:0] count_ff;

  // ==========================================================
  // Countdown of the remaining cycles
  // ==========================================================
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_ff <= EXTRA_NONE;
    end else if (i_ce) begin
      if (i_load) begin
        count_ff <= i_extra;
      end else if (count_ff != EXTRA_NONE) begin
        count_ff <= count_ff - 2'h1;
      end
    end
  end

  assign o_fire = i_ce && (count_ff == COUNT_LAST);

endmodule : mcu8_cycle_timer

// ===== rtl/mcu8_alu_core.sv
`timescale 1ns/1ps
module mcu8_alu_core
  import mcu8_exec_pkg::*;
(
  input wire op_t i_op,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_mem,
  input wire logic [7:0] i_imm,
  input wire logic [7:0] i_addr,
  input wire logic [2:0] i_bit,
  input wire logic i_carry,
  output logic [7:0] o_acc_val,
  output logic [7:0] o_mem_val,
  output logic o_wr_acc,
  output logic o_wr_mem,
  output logic o_c,
  output logic o_dc,
  output logic o_z,
  output logic o_upd_c,
  output logic o_upd_dc,
  output logic o_upd_z
);

  // Returns {carry out, carry out of bit 3, sum}
  function automatic logic [9:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    add8 = {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction : add8

  logic [9:0] sum;
  logic [7:0] b_opnd;
  logic cin;
  logic [7:0] bit_mask;

  always_comb begin
    bit_mask = 8'h01 << i_bit;
    unique case (i_op)
      OP_ADD_I, OP_SUB_I, OP_AND_I, OP_OR_I, OP_XOR_I: b_opnd = i_imm;
      default: b_opnd = i_mem;
    endcase
    // Subtraction as A + ~M + C: carry out means no borrow
    unique case (i_op)
      OP_ADC_A, OP_ADC_M: cin = i_carry;
      OP_SBC_A, OP_SBC_M: cin = i_carry;
      OP_SUB_A, OP_SUB_M, OP_SUB_I: cin = 1'b1;
      default: cin = 1'b0;
    endcase
    unique case (i_op)
      OP_SBC_A, OP_SBC_M, OP_SUB_A, OP_SUB_M, OP_SUB_I: begin
        sum = add8(i_acc, ~b_opnd, cin);
      end
      default: sum = add8(i_acc, b_opnd, cin);
    endcase
  end

  always_comb begin
    o_acc_val = i_acc;
    o_mem_val = i_mem;
    o_wr_acc = 1'b0;
    o_wr_mem = 1'b0;
    o_c = i_carry;
    o_dc = sum[8];
    o_upd_c = 1'b0;
    o_upd_dc = 1'b0;
    o_upd_z = 1'b0;
    unique case (i_op)
      OP_MOV_A_M, OP_MOVB0_A_M: begin
        o_acc_val = i_mem;
        o_wr_acc = 1'b1;
        o_upd_z = 1'b1;
      end
      OP_MOV_M_A, OP_MOVB0_M_A: begin
        o_mem_val = i_acc;
        o_wr_mem = 1'b1;
      end
      OP_MOV_A_I: begin
        o_acc_val = i_imm;
        o_wr_acc = 1'b1;
      end
      OP_MOVB0_M_I: begin
        o_mem_val = i_imm;
        // Writes outside the small system window are dropped
        o_wr_mem = (i_addr >= SYSREG_IMM_LO) && (i_addr <= SYSREG_IMM_HI);
      end
      OP_XCH, OP_XCHB0: begin
        o_acc_val = i_mem;
        o_mem_val = i_acc;
        o_wr_acc = 1'b1;
        o_wr_mem = 1'b1;
      end
      OP_ADC_A, OP_ADD_A, OP_ADD_I, OP_SBC_A, OP_SUB_A, OP_SUB_I: begin
        o_acc_val = sum[7:0];
        o_wr_acc = 1'b1;
        o_c = sum[9];
        {o_upd_c, o_upd_dc, o_upd_z} = 3'b111;
      end
      OP_ADC_M, OP_ADD_M, OP_SBC_M, OP_SUB_M: begin
        o_mem_val = sum[7:0];
        o_wr_mem = 1'b1;
        o_c = sum[9];
        {o_upd_c, o_upd_dc, o_upd_z} = 3'b111;
      end
      OP_ADDB0_M: begin
        o_mem_val = sum[7:0];
        o_wr_mem = 1'b1;
        o_c = sum[9];
        {o_upd_c, o_upd_z} = 2'b11;
      end
      OP_AND_A, OP_AND_I: begin
        o_acc_val = i_acc & b_opnd;
        o_wr_acc = 1'b1;
        o_upd_z = 1'b1;
      end
      OP_OR_A, OP_OR_I: begin
        o_acc_val = i_acc | b_opnd;
        o_wr_acc = 1'b1;
        o_upd_z = 1'b1;
      end
      OP_XOR_A, OP_XOR_I: begin
        o_acc_val = i_acc ^ b_opnd;
        o_wr_acc = 1'b1;
        o_upd_z = 1'b1;
      end
      OP_AND_M, OP_OR_M, OP_XOR_M: begin
        o_mem_val = (i_op == OP_AND_M) ? (i_acc & i_mem) :
                    (i_op == OP_OR_M) ? (i_acc | i_mem) : (i_acc ^ i_mem);
        o_wr_mem = 1'b1;
        o_upd_z = 1'b1;
      end
      OP_SWAP_A: begin
        o_acc_val = {i_mem[3:0], i_mem[7:4]};
        o_wr_acc = 1'b1;
      end
      OP_SWAP_M: begin
        o_mem_val = {i_mem[3:0], i_mem[7:4]};
        o_wr_mem = 1'b1;
      end
      OP_RRC_A, OP_RRC_M: begin
        o_acc_val = {i_carry, i_mem[7:1]};
        o_mem_val = {i_carry, i_mem[7:1]};
        o_wr_acc = (i_op == OP_RRC_A);
        o_wr_mem = (i_op == OP_RRC_M);
        o_c = i_mem[0];
        o_upd_c = 1'b1;
      end
      OP_RLC_A, OP_RLC_M: begin
        o_acc_val = {i_mem[6:0], i_carry};
        o_mem_val = {i_mem[6:0], i_carry};
        o_wr_acc = (i_op == OP_RLC_A);
        o_wr_mem = (i_op == OP_RLC_M);
        o_c = i_mem[7];
        o_upd_c = 1'b1;
      end
      OP_CLR: begin
        o_mem_val = BYTE_ZERO;
        o_wr_mem = 1'b1;
      end
      OP_BIT_CLEAR: begin
        o_mem_val = i_mem & ~bit_mask;
        o_wr_mem = 1'b1;
      end
      OP_BIT_SET: begin
        o_mem_val = i_mem | bit_mask;
        o_wr_mem = 1'b1;
      end
      default: begin
        o_wr_acc = 1'b0;
      end
    endcase
    o_z = o_wr_acc ? (o_acc_val == BYTE_ZERO) : (o_mem_val == BYTE_ZERO);
  end

endmodule : mcu8_alu_core

// ===== rtl/mcu8_move_arith_logic_exec.sv
// Functional notes
// - Bank-zero load: acc gets byte, Z only
// - Bank-zero store: acc to memory, no flags
// - Immediate move only to 0x80..0x87, one cycle
// - Exchange swaps acc and memory, 1+N, flagless
// - Table read Y:Z into R and acc, 2
// - Add with carry sets C, DC, Z
// - Immediate add sets carry, one cycle
// - Bank-zero add writes memory, C and Z, 1+N
// - Subtract with borrow: C cleared on borrow
// - Plain subtract ignores carry, 1 or 1+N
// - Immediate subtract, C cleared on borrow
// - Logic ops touch Z only; 1 or 1+N
// - Nibble swap, no flags, 1 or 1+N
// - Rotates through carry, C only
// - Bit clear/set 1+N; byte clear one cycle
// - N is 0 for sysreg, 1 for RAM
`timescale 1ns/1ps
module mcu8_move_arith_logic_exec
  import mcu8_exec_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_start,
  input wire op_t i_op,
  input wire logic [7:0] i_mem_addr,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [7:0] i_imm,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_ptr_y,
  input wire logic [7:0] i_ptr_z,
  input wire logic [15:0] i_rom_data,
  output logic [7:0] o_acc_ff,
  output logic [7:0] o_r_ff,
  output logic o_carry_ff,
  output logic o_half_carry_ff,
  output logic o_zero_ff,
  output logic o_mem_we_ff,
  output logic [7:0] o_mem_addr_ff,
  output logic [7:0] o_mem_wdata_ff,
  output logic o_mem_bank0_ff,
  output logic o_rom_rd_ff,
  output logic [15:0] o_rom_addr_ff,
  output logic o_busy_ff,
  output logic o_done_ff
);

  // ==========================================================
  // Issue and cycle timing
  // ==========================================================
  logic accept;
  logic [1:0] extra;
  logic fire;
  logic commit;

  assign accept = i_ce && i_start && !o_busy_ff;
  assign extra = extra_cycles(i_op, i_mem_addr);
  assign commit = (accept && (extra == EXTRA_NONE)) || fire;

  mcu8_cycle_timer u_timer (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_load(accept),
    .i_extra(extra),
    .o_fire(fire)
  );

  // ==========================================================
  // Function unit
  // ==========================================================
  logic [7:0] alu_acc;
  logic [7:0] alu_mem;
  logic alu_wr_acc;
  logic alu_wr_mem;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic alu_upd_c;
  logic alu_upd_dc;
  logic alu_upd_z;

  mcu8_alu_core u_alu (
    .i_op(i_op),
    .i_acc(o_acc_ff),
    .i_mem(i_mem_rdata),
    .i_imm(i_imm),
    .i_addr(i_mem_addr),
    .i_bit(i_bit_sel),
    .i_carry(o_carry_ff),
    .o_acc_val(alu_acc),
    .o_mem_val(alu_mem),
    .o_wr_acc(alu_wr_acc),
    .o_wr_mem(alu_wr_mem),
    .o_c(alu_c),
    .o_dc(alu_dc),
    .o_z(alu_z),
    .o_upd_c(alu_upd_c),
    .o_upd_dc(alu_upd_dc),
    .o_upd_z(alu_upd_z)
  );

  // ==========================================================
  // Pending results of a multi-cycle operation
  // ==========================================================
  // Results are computed at issue so the operand bus is free
  // for the sequencer while the extra cycle runs.
  logic [7:0] pend_acc_ff;
  logic [7:0] pend_mem_ff;
  logic pend_wr_acc_ff;
  logic pend_wr_mem_ff;
  logic pend_rom_ff;
  logic [5:0] pend_flag_ff;
  logic [7:0] pend_addr_ff;
  logic pend_bank0_ff;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_acc_ff <= ACC_RST;
      pend_mem_ff <= BYTE_ZERO;
      pend_wr_acc_ff <= 1'b0;
      pend_wr_mem_ff <= 1'b0;
      pend_rom_ff <= 1'b0;
      pend_flag_ff <= 6'h00;
      pend_addr_ff <= BYTE_ZERO;
      pend_bank0_ff <= 1'b0;
    end else if (i_ce && accept) begin
      pend_acc_ff <= alu_acc;
      pend_mem_ff <= alu_mem;
      pend_wr_acc_ff <= alu_wr_acc;
      pend_wr_mem_ff <= alu_wr_mem;
      pend_rom_ff <= (i_op == OP_ROMRD);
      pend_flag_ff <= {alu_upd_c, alu_upd_dc, alu_upd_z,
                       alu_c, alu_dc, alu_z};
      pend_addr_ff <= i_mem_addr;
      pend_bank0_ff <= is_bank0(i_op);
    end
  end

  // Commit source: the unit itself for one-cycle work
  logic [7:0] nxt_acc_val;
  logic [7:0] nxt_mem_val;
  logic nxt_wr_acc;
  logic nxt_wr_mem;
  logic [5:0] nxt_flag;
  logic [7:0] nxt_addr;
  logic nxt_bank0;

  always_comb begin
    if (fire) begin
      nxt_acc_val = pend_rom_ff ? i_rom_data[7:0] : pend_acc_ff;
      nxt_mem_val = pend_mem_ff;
      nxt_wr_acc = pend_wr_acc_ff || pend_rom_ff;
      nxt_wr_mem = pend_wr_mem_ff;
      nxt_flag = pend_flag_ff;
      nxt_addr = pend_addr_ff;
      nxt_bank0 = pend_bank0_ff;
    end else begin
      nxt_acc_val = alu_acc;
      nxt_mem_val = alu_mem;
      nxt_wr_acc = alu_wr_acc;
      nxt_wr_mem = alu_wr_mem;
      nxt_flag = {alu_upd_c, alu_upd_dc, alu_upd_z, alu_c, alu_dc, alu_z};
      nxt_addr = i_mem_addr;
      nxt_bank0 = is_bank0(i_op);
    end
  end

  // ==========================================================
  // Accumulator, R and status flags
  // ==========================================================
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_acc_ff <= ACC_RST;
      o_r_ff <= R_RST;
    end else if (i_ce && commit) begin
      if (fire && pend_rom_ff) begin
        o_r_ff <= i_rom_data[15:8];
      end
      if (nxt_wr_acc) begin
        o_acc_ff <= nxt_acc_val;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_carry_ff <= FLAG_RST;
      o_half_carry_ff <= FLAG_RST;
      o_zero_ff <= FLAG_RST;
    end else if (i_ce && commit) begin
      if (nxt_flag[5]) begin
        o_carry_ff <= nxt_flag[2];
      end
      if (nxt_flag[4]) begin
        o_half_carry_ff <= nxt_flag[1];
      end
      if (nxt_flag[3]) begin
        o_zero_ff <= nxt_flag[0];
      end
    end
  end

  // ==========================================================
  // Memory write port, ROM port and handshake
  // ==========================================================
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_we_ff <= 1'b0;
      o_mem_addr_ff <= BYTE_ZERO;
      o_mem_wdata_ff <= BYTE_ZERO;
      o_mem_bank0_ff <= 1'b0;
    end else if (i_ce) begin
      o_mem_we_ff <= commit && nxt_wr_mem;
      if (commit) begin
        o_mem_addr_ff <= nxt_addr;
        o_mem_wdata_ff <= nxt_mem_val;
        o_mem_bank0_ff <= nxt_bank0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rom_rd_ff <= 1'b0;
      o_rom_addr_ff <= ROM_ADDR_RST;
    end else if (i_ce) begin
      o_rom_rd_ff <= accept && (i_op == OP_ROMRD);
      if (accept && (i_op == OP_ROMRD)) begin
        o_rom_addr_ff <= {i_ptr_y, i_ptr_z};
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy_ff <= 1'b0;
      o_done_ff <= 1'b0;
    end else if (i_ce) begin
      o_done_ff <= commit;
      if (accept && (extra != EXTRA_NONE)) begin
        o_busy_ff <= 1'b1;
      end else if (fire) begin
        o_busy_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_bank0_load;
    accept && (i_op == OP_MOVB0_A_M) |=> o_done_ff &&
      (o_acc_ff == $past(i_mem_rdata)) && $stable(o_carry_ff) &&
      $stable(o_half_carry_ff) && (o_zero_ff == (o_acc_ff == BYTE_ZERO));
  endproperty
  a_bank0_load: assert property (p_bank0_load)
    else $error("bank-zero load result or flags wrong");

  property p_bank0_store;
    accept && (i_op == OP_MOVB0_M_A) |=> o_mem_we_ff && o_mem_bank0_ff &&
      (o_mem_wdata_ff == $past(o_acc_ff)) && $stable(o_carry_ff) &&
      $stable(o_zero_ff);
  endproperty
  a_bank0_store: assert property (p_bank0_store)
    else $error("bank-zero store wrong");

  property p_imm_window;
    accept && (i_op == OP_MOVB0_M_I) |=> o_done_ff &&
      (o_mem_we_ff == (($past(i_mem_addr) >= SYSREG_IMM_LO) &&
                       ($past(i_mem_addr) <= SYSREG_IMM_HI)));
  endproperty
  a_imm_window: assert property (p_imm_window)
    else $error("immediate move outside window handled wrongly");

  property p_rom_read;
    accept && (i_op == OP_ROMRD) ##1 i_ce |=> o_done_ff &&
      (o_acc_ff == $past(i_rom_data[7:0])) &&
      (o_r_ff == $past(i_rom_data[15:8])) && $stable(o_carry_ff);
  endproperty
  a_rom_read: assert property (p_rom_read)
    else $error("table read did not land in R and acc");

  property p_adc_acc;
    accept && (i_op == OP_ADC_A) |=> {o_carry_ff, o_acc_ff} ==
      ({1'b0, $past(o_acc_ff)} + {1'b0, $past(i_mem_rdata)} +
       {8'h00, $past(o_carry_ff)});
  endproperty
  a_adc_acc: assert property (p_adc_acc)
    else $error("add with carry sum or carry wrong");

  property p_sub_carry;
    accept && (i_op == OP_SUB_A) |=> o_done_ff &&
      (o_carry_ff == ($past(o_acc_ff) >= $past(i_mem_rdata))) &&
      (o_acc_ff == $past(o_acc_ff) - $past(i_mem_rdata));
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("subtract borrow sense wrong");

  property p_logic_flags;
    accept && (i_op == OP_AND_A) |=> $stable(o_carry_ff) &&
      $stable(o_half_carry_ff) && (o_acc_ff ==
      ($past(o_acc_ff) & $past(i_mem_rdata)));
  endproperty
  a_logic_flags: assert property (p_logic_flags)
    else $error("logic op disturbed carry flags");

  property p_rotate_left;
    accept && (i_op == OP_RLC_A) |=> (o_carry_ff == $past(i_mem_rdata[7]))
      && (o_acc_ff == {$past(i_mem_rdata[6:0]), $past(o_carry_ff)});
  endproperty
  a_rotate_left: assert property (p_rotate_left)
    else $error("rotate left through carry wrong");

  property p_ram_extra;
    accept && (i_op == OP_AND_M) && is_ram(i_mem_addr) ##1 i_ce
      |-> !o_done_ff && o_busy_ff ##1 o_done_ff && o_mem_we_ff;
  endproperty
  a_ram_extra: assert property (p_ram_extra)
    else $error("RAM operand did not take the extra cycle");

  property p_half_carry;
    accept && (i_op == OP_ADD_A) |=> o_half_carry_ff ==
      (({1'b0, $past(o_acc_ff[3:0])} + {1'b0, $past(i_mem_rdata[3:0])})
       > 5'h0F);
  endproperty
  a_half_carry: assert property (p_half_carry)
    else $error("half carry does not match bit 3 carry");

  c_rom_read: cover property (accept && (i_op == OP_ROMRD) ##2 o_done_ff);
  c_xch_ram: cover property (accept && (i_op == OP_XCH) ##2 o_mem_we_ff);
  c_sbc_borrow: cover property (accept && (i_op == OP_SBC_A) ##1
                                !o_carry_ff);
  c_back_to_back: cover property (accept ##1 accept);

endmodule : mcu8_move_arith_logic_exec

// ===== tb/mcu8_rom_table_model.sv
`timescale 1ns/1ps
module mcu8_rom_table_model (
  input wire logic i_mclk,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  output logic [15:0] o_data
);
  // ==========================================================
  // Program ROM seen through the table-read port
  // ==========================================================
  logic rd_d_ff;
  logic [15:0] last_ff;
  always_ff @(posedge i_mclk) begin
    rd_d_ff <= i_rd;
    last_ff <= o_data;
  end
  // word from pointer pair
  // Outside the read window the word flips every cycle, so a late
  // or early capture cannot pass by luck
  always_comb begin
    if (i_rd || rd_d_ff) begin
      o_data = {i_addr[7:0] ^ 8'h5c, i_addr[15:8] ^ 8'ha3};
    end else begin
      o_data = ~last_ff;
    end
  end
endmodule : mcu8_rom_table_model

// ===== tb/test_mcu8_move_arith_logic_exec.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_mcu8_move_arith_logic_exec;
  import mcu8_exec_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, start = 0, saw_we;
  logic [1:0] saw_bz;
  op_t op = OP_MOV_A_I;
  logic [7:0] addr = 0, rdata = 0, imm = 0, py = 0, pz = 0;
  logic [2:0] bsel = 0;
  logic [15:0] romd;
  logic [7:0] acc, r, waddr, wdata;
  logic c, dc, z, we, b0, rrd, busy, done, last_dc = 0;
  logic [15:0] raddr;
  int n_mismatch = 0, total_checks = 0, cyc;
  always #5 clk = ~clk;
  mcu8_move_arith_logic_exec dut (.i_mclk(clk), .i_rst_n(rst_n),
    .i_ce(ce), .i_start(start), .i_op(op), .i_mem_addr(addr),
    .i_mem_rdata(rdata), .i_imm(imm), .i_bit_sel(bsel), .i_ptr_y(py),
    .i_ptr_z(pz), .i_rom_data(romd), .o_acc_ff(acc), .o_r_ff(r),
    .o_carry_ff(c), .o_half_carry_ff(dc), .o_zero_ff(z),
    .o_mem_we_ff(we), .o_mem_addr_ff(waddr), .o_mem_wdata_ff(wdata),
    .o_mem_bank0_ff(b0), .o_rom_rd_ff(rrd), .o_rom_addr_ff(raddr),
    .o_busy_ff(busy), .o_done_ff(done));
  mcu8_rom_table_model rom (.i_mclk(clk), .i_rd(rrd), .i_addr(raddr),
    .o_data(romd));
  // ==========================================================
  // Shared helpers
  // ==========================================================
  function automatic logic [9:0] sum(input logic [7:0] a, b,
                                     input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    sum = {s[8], h[4], s[7:0]};
  endfunction : sum
  task automatic run(input op_t o, input logic [7:0] a, m, i,
                     input logic [2:0] b);
    // Idle cycle first, so no input changes twice in one time step
    @(negedge clk);
    op = o; addr = a; rdata = m; imm = i; bsel = b; start = 1;
    saw_we = 0; saw_bz = 2'b00;
    @(negedge clk);
    // Operand is only valid in the take cycle
    start = 0; rdata = ~m; cyc = 1;
    while (done !== 1'b1 && cyc < 8) begin
      saw_we |= (we === 1'b1);
      saw_bz |= {busy === 1'b1, rrd === 1'b1};
      @(negedge clk);
      cyc++;
    end
    saw_we |= (we === 1'b1);
  endtask : run
  // Sets carry to a known level through a rotate of the operand byte into the accumulator
  task automatic set_c(input logic v);
    run(OP_RRC_A, 8'h10, {7'h00, v}, 8'h00, 3'h0);
  endtask : set_c
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_moves();
    set_c(1'b1);
    run(OP_MOV_A_I, 8'h10, 8'h00, 8'h5a, 3'h0);
    run(OP_MOVB0_M_A, 8'h12, 8'hff, 8'h00, 3'h0);
    `CHK({saw_we, b0, waddr, wdata, c}, {2'b11, 8'h12, 8'h5a, 1'b1})
    `CHK(cyc, 1)
    run(OP_MOVB0_A_M, 8'h13, 8'h00, 8'h00, 3'h0);
    `CHK({acc, z, c, cyc[1:0]}, {8'h00, 2'b11, 2'd1})
    run(OP_MOVB0_M_I, 8'h87, 8'h00, 8'h3c, 3'h0);
    `CHK({saw_we, waddr, wdata, cyc[1:0]}, {1'b1, 16'h873c, 2'd1})
    run(OP_MOVB0_M_I, 8'h88, 8'h00, 8'h3c, 3'h0);
    `CHK({saw_we, done}, 2'b01)
  endtask : t_moves
  task automatic t_xch();
    run(OP_MOV_A_I, 8'h10, 8'h00, 8'h11, 3'h0);
    run(OP_XCH, 8'h10, 8'h22, 8'h00, 3'h0);
    `CHK({acc, wdata, saw_we, cyc[1:0]}, {16'h2211, 1'b1, 2'd2})
    `CHK(saw_bz, 2'b10)
    run(OP_XCHB0, 8'h81, 8'h33, 8'h00, 3'h0);
    `CHK({acc, wdata, b0, cyc[1:0]}, {16'h3322, 1'b1, 2'd1})
  endtask : t_xch
  task automatic t_rom();
    py = 8'h12; pz = 8'h34;
    run(OP_ROMRD, 8'h10, 8'h00, 8'h00, 3'h0);
    `CHK({raddr, cyc[1:0]}, {16'h1234, 2'd2})
    `CHK({r, acc}, {8'h68, 8'hb1})
    `CHK(saw_bz, 2'b11)
  endtask : t_rom
  // Memory-destination ops check the written byte and 1+N timing
  task automatic arith(input op_t o, input logic [7:0] a, m,
                       input logic ci, sb, usec, input logic [7:0] ad);
    logic [9:0] e;
    logic tomem;
    tomem = o inside {OP_ADC_M, OP_SBC_M, OP_ADD_M, OP_SUB_M,
                      OP_ADDB0_M};
    e = sum(a, sb ? ~m : m, usec ? ci : sb);
    set_c(ci);
    run(OP_MOV_A_I, 8'h10, 8'h00, a, 3'h0);
    run(o, ad, m, m, 3'h0);
    `CHK({c, z}, {e[9], e[7:0] == 8'h00})
    if (o == OP_ADDB0_M) begin
      `CHK(dc, last_dc)
    end else begin
      `CHK(dc, e[8])
      last_dc = e[8];
    end
    if (tomem) begin
      `CHK({wdata, saw_we}, {e[7:0], 1'b1})
      `CHK(cyc, ad[7] ? 1 : 2)
    end else begin
      `CHK({acc, cyc[1:0]}, {e[7:0], 2'd1})
    end
  endtask : arith
  task automatic t_arith();
    arith(OP_ADC_A, 8'h8f, 8'h71, 1, 0, 1, 8'h10);
    arith(OP_ADD_A, 8'h08, 8'h08, 1, 0, 0, 8'h10);
    arith(OP_ADD_I, 8'hf0, 8'h20, 0, 0, 0, 8'h10);
    arith(OP_SUB_A, 8'h10, 8'h20, 0, 1, 0, 8'h10);
    arith(OP_SBC_A, 8'h05, 8'h05, 0, 1, 1, 8'h10);
    arith(OP_SBC_M, 8'h05, 8'h05, 1, 1, 1, 8'h10);
    arith(OP_SUB_I, 8'h33, 8'h03, 0, 1, 0, 8'h10);
    arith(OP_ADC_M, 8'h0f, 8'h01, 0, 0, 1, 8'h82);
    arith(OP_ADD_M, 8'h80, 8'h80, 0, 0, 0, 8'h10);
    arith(OP_SUB_M, 8'h44, 8'h45, 1, 1, 0, 8'h84);
    arith(OP_ADDB0_M, 8'hff, 8'h01, 0, 0, 0, 8'h10);
  endtask : t_arith
  task automatic t_logic();
    set_c(1'b1);
    run(OP_MOV_A_I, 8'h10, 8'h00, 8'hf0, 3'h0);
    run(OP_AND_M, 8'h10, 8'h0f, 8'h00, 3'h0);
    `CHK({wdata, z, c, saw_we, cyc[1:0]}, {8'h00, 3'b111, 2'd2})
    run(OP_OR_I, 8'h10, 8'h00, 8'h01, 3'h0);
    `CHK({acc, z, cyc[1:0]}, {8'hf1, 1'b0, 2'd1})
    run(OP_XOR_A, 8'h10, 8'hf1, 8'h00, 3'h0);
    `CHK({acc, z}, {8'h00, 1'b1})
    run(OP_OR_A, 8'h10, 8'h3c, 8'h00, 3'h0);
    run(OP_AND_A, 8'h10, 8'hf5, 8'h00, 3'h0);
    run(OP_AND_I, 8'h10, 8'hff, 8'h0f, 3'h0);
    `CHK({acc, z}, {8'h04, 1'b0})
    run(OP_XOR_M, 8'h86, 8'h04, 8'h00, 3'h0);
    `CHK({wdata, z, cyc[1:0]}, {8'h00, 1'b1, 2'd1})
    run(OP_XOR_I, 8'h10, 8'h00, 8'h04, 3'h0);
    `CHK({acc, z}, {8'h00, 1'b1})
    run(OP_SWAP_A, 8'h10, 8'ha5, 8'h00, 3'h0);
    `CHK({acc, z, cyc[1:0]}, {8'h5a, 1'b1, 2'd1})
    run(OP_SWAP_M, 8'h10, 8'hc3, 8'h00, 3'h0);
    `CHK({wdata, cyc[1:0]}, {8'h3c, 2'd2})
    run(OP_RLC_M, 8'h85, 8'h80, 8'h00, 3'h0);
    `CHK({wdata, c, cyc[1:0]}, {8'h01, 1'b1, 2'd1})
    run(OP_RRC_M, 8'h10, 8'h02, 8'h00, 3'h0);
    `CHK({wdata, c, cyc[1:0]}, {8'h81, 1'b0, 2'd2})
    run(OP_RLC_A, 8'h10, 8'h81, 8'h00, 3'h0);
    `CHK({acc, c, cyc[1:0]}, {8'h02, 1'b1, 2'd1})
    run(OP_BIT_SET, 8'h20, 8'h00, 8'h00, 3'h3);
    `CHK({wdata, cyc[1:0]}, {8'h08, 2'd2})
    run(OP_BIT_CLEAR, 8'h90, 8'hff, 8'h00, 3'h7);
    `CHK({wdata, cyc[1:0]}, {8'h7f, 2'd1})
    run(OP_CLR, 8'h20, 8'h55, 8'h00, 3'h0);
    `CHK({wdata, saw_we, cyc[1:0]}, {8'h00, 1'b1, 2'd1})
  endtask : t_logic
  // ==========================================================
  // Sequence and verdict
  // ==========================================================
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1;
    t_moves();
    t_xch();
    t_rom();
    t_arith();
    t_logic();
    summarize();
  end
  // Whole run needs well under 500 cycles
  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end
endmodule : test_mcu8_move_arith_logic_exec
